// ===== rtc_calendar.sv
// Chosen here: the address map and strobed register access.
`timescale 1ns/100ps
// Notes on behaviour
// - minute readable anytime, write loads counter
// - minute writes above 59 ignored
// - minute wraps to zero after 59
// - hour readable; writes 0..23 load, else ignored
// - hour wraps to zero after 23
// - hour count in bits four to zero
// - 16-bit counter resets on active modulo match
// - source selectable, main oscillator after reset
// - main source prescaled then divided by 32
// - low-frequency oscillator enable sticks until reset
// - calendar increments set flags, enables gate requests
// - compensation cycle 5, 15, 30, 60 seconds
// - flag at last second of compensation cycle
// - 4 Hz tick sets flag, requests interrupt
// - first Q seconds use modulo plus one
// - Q at period all plus-one, zero none
// - protect control one and calendar registers
// - write-enable sequence tracked by state machine
// - protection disabled after any reset
// - working settings reload at cycle end
// - busy flag blocks modulo and config writes
// - calibration clock offered for measurement
// - selection 00=5, 01=15, 10=30, 11=60
// - flags clear on write one, reset clears
module rtc_calendar
    import rtc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [15:0]      reg_rdata,
    input  wire logic        main_osc_clock,
    input  wire logic        low_freq_osc_clock,
    output logic             low_freq_osc_enable,
    output logic             calibration_clock,
    output logic             second_irq,
    output logic             minute_irq,
    output logic             hour_irq,
    output logic             comp_irq,
    output logic             tick_irq
);
    // ******************************************************
    // Register state
    // ******************************************************
    // Software-visible control
    logic [7:0]  control_one_q;
    logic [7:0]  control_four_q;
    logic [7:0]  prescale_q;

    // Compensation settings, programmed then working
    logic [15:0] modulo_value_q;
    logic [7:0]  compensation_config_q;
    logic [15:0] mod_work_q;
    logic [7:0]  ccr_work_q;

    // Counting state
    logic [15:0] free_run_count_q;
    logic [5:0]  second_count_q;
    logic [5:0]  minute_count_q;
    logic [4:0]  hour_count_q;
    logic [5:0]  cycle_sec_q;

    // Sticky enable and reload busy
    logic        lfosc_sticky_q;
    logic        busy_q;

    // Event flags
    logic        hour_flag_q;
    logic        minute_flag_q;
    logic        second_flag_q;
    logic        comp_flag_q;
    logic        tick_flag_q;

    // Outputs kept in flip-flops
    logic        cal_clk_q;
    logic [15:0] rdata_q;

    // ******************************************************
    // Decode
    // ******************************************************
    logic        protect_on;
    logic [1:0]  protect_state;
    logic        count_en;

    // Address decode, one strobe per writable register
    wire         wr_ctl1   = reg_write && reg_addr == ADDR_CONTROL_ONE;
    wire         wr_ctl3   = reg_write && reg_addr == ADDR_CONTROL_THREE;
    wire         wr_ctl4   = reg_write && reg_addr == ADDR_CONTROL_FOUR;
    wire         wr_stat   = reg_write && reg_addr == ADDR_STATUS;
    wire         wr_ccr    = reg_write && reg_addr == ADDR_COMP_CONFIG;
    wire         wr_mod    = reg_write && reg_addr == ADDR_MODULO;
    wire         wr_sec    = reg_write && reg_addr == ADDR_SECOND;
    wire         wr_min    = reg_write && reg_addr == ADDR_MINUTE;
    wire         wr_hour   = reg_write && reg_addr == ADDR_HOUR;
    wire         wr_pre    = reg_write && reg_addr == ADDR_PRESCALE;
    // Protected registers only accept writes while unlocked
    wire         ctl1_ok   = wr_ctl1 && !protect_on;
    wire         sec_ok    = wr_sec && !protect_on &&
                             reg_wdata[7:0] <= {2'b00, SECOND_MAX};
    wire         min_ok    = wr_min && !protect_on &&
                             reg_wdata[7:0] <= {2'b00, MINUTE_MAX};
    wire         hour_ok   = wr_hour && !protect_on &&
                             reg_wdata[7:0] <= {3'b000, HOUR_MAX};

    // Busy blocks writes so the reload sees stable data
    wire         mod_ok    = wr_mod && !busy_q;
    wire         ccr_ok    = wr_ccr && !busy_q;
    // Control one fields
    wire         module_enable = control_one_q[CTL1_ENABLE_BIT];
    wire         source_select = control_one_q[CTL1_SOURCE_BIT];

    // ******************************************************
    // Compensation arithmetic
    // ******************************************************
    logic [5:0]  period_sec;
    // Working fields hold still between reloads
    wire  [1:0]  ccs_work = ccr_work_q[CCR_CCS_MSB:CCR_CCS_LSB];
    wire  [5:0]  q_work   = ccr_work_q[CCR_Q_MSB:CCR_Q_LSB];
    // Plus-one while second index below Q; Q >= period covers all
    wire         use_plus = cycle_sec_q < q_work;
    wire  [16:0] active_mod = {1'b0, mod_work_q} +
                              {16'h0000, use_plus};
    wire         match    = count_en &&
                            {1'b0, free_run_count_q} == active_mod;
    wire         sec_tick = match;

    // Cycle end closes the final second
    wire         last_sec = cycle_sec_q == period_sec - 6'h01;
    wire         cyc_end  = sec_tick && last_sec;
    wire         comp_set = sec_tick &&
                            cycle_sec_q == period_sec - 6'h02;
    // Carries ripple in the tick's own cycle
    wire         sec_wrap = sec_tick && second_count_q == SECOND_MAX;
    wire         min_wrap = sec_wrap && minute_count_q == MINUTE_MAX;

    // Quarter-second points of the active second
    wire  [15:0] quarter  = {1'b0, active_mod[16:2]};
    wire         qtr_tick = count_en && !match && quarter != 16'h0000 &&
                            (free_run_count_q == quarter ||
                             free_run_count_q == {quarter[14:0], 1'b0} ||
                             free_run_count_q == 16'(quarter * 3));
    wire         tb_event = qtr_tick || sec_tick;

    // Cycle length table
    always_comb begin
        case (ccs_work)
            2'b00:   period_sec = PERIOD_SEL0;
            2'b01:   period_sec = PERIOD_SEL1;
            2'b10:   period_sec = PERIOD_SEL2;
            2'b11:   period_sec = PERIOD_SEL3;
            default: period_sec = PERIOD_SEL0;
        endcase
    end

    // ******************************************************
    // Submodules
    // ******************************************************
    // Count enable from the selected source
    rtc_tick_div u_div (
        .core_clk           (core_clk),
        .sys_rst            (sys_rst),
        .run                (module_enable),
        .use_low_freq       (source_select),
        .prescale_value     (prescale_q),
        .main_osc_clock     (main_osc_clock),
        .low_freq_osc_clock (low_freq_osc_clock),
        .count_en           (count_en)
    );

    // Unlock tracker on control three
    rtc_protect_fsm u_protect (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .we_write      (wr_ctl3),
        .we_data       (reg_wdata[1:0]),
        .protect_on    (protect_on),
        .protect_state (protect_state)
    );

    // ******************************************************
    // Control registers
    // ******************************************************
    // Software sets prescale and source before enable
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            control_one_q  <= CTL_RESET;
            control_four_q <= CTL_RESET;
            prescale_q     <= PRESCALE_RESET;
        end else begin
            if (ctl1_ok) control_one_q <= reg_wdata[7:0];
            if (wr_ctl4) control_four_q <= reg_wdata[7:0];
            if (wr_pre) prescale_q <= reg_wdata[7:0];
        end
    end

    // Oscillator enable can only be set; cleared by reset alone
    always_ff @(posedge core_clk) begin
        if (sys_rst) lfosc_sticky_q <= 1'b0;
        else if (ctl1_ok && reg_wdata[CTL1_LFOSC_BIT])
            lfosc_sticky_q <= 1'b1;
    end

    // Programmable and buffered compensation settings
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            modulo_value_q        <= MODULO_RESET;
            compensation_config_q <= CCR_RESET;
            mod_work_q            <= MODULO_RESET;
            ccr_work_q            <= CCR_RESET;
            busy_q                <= 1'b0;
        end else begin
            if (mod_ok) modulo_value_q <= reg_wdata;
            if (ccr_ok) compensation_config_q <= reg_wdata[7:0];
            // Load takes one cycle after the cycle end; busy covers it
            busy_q <= cyc_end;
            if (busy_q) begin
                mod_work_q <= modulo_value_q;
                ccr_work_q <= compensation_config_q;
            end
        end
    end

    // ******************************************************
    // Counters
    // ******************************************************
    // Disable clears count and cycle position
    always_ff @(posedge core_clk) begin
        if (sys_rst || !module_enable) begin
            free_run_count_q <= 16'h0000;
            cycle_sec_q      <= 6'h00;
        end else if (match) begin
            free_run_count_q <= 16'h0000;
            cycle_sec_q      <= last_sec ? 6'h00 : cycle_sec_q + 6'h01;
        end else if (count_en) begin
            free_run_count_q <= free_run_count_q + 16'h0001;
        end
    end

    // Calendar: a legal write wins over a tick in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            second_count_q <= 6'h00;
            minute_count_q <= 6'h00;
            hour_count_q   <= 5'h00;
        end else begin
            if (sec_ok) second_count_q <= reg_wdata[5:0];
            else if (sec_tick)
                second_count_q <= sec_wrap ? 6'h00 : second_count_q + 6'h01;
            if (min_ok) minute_count_q <= reg_wdata[5:0];
            else if (sec_wrap)
                minute_count_q <= (minute_count_q == MINUTE_MAX) ?
                                  6'h00 : minute_count_q + 6'h01;
            if (hour_ok)
                hour_count_q <= reg_wdata[HOUR_FIELD_MSB:0];
            else if (min_wrap)
                hour_count_q <= (hour_count_q == HOUR_MAX) ?
                                5'h00 : hour_count_q + 5'h01;
        end
    end

    // ******************************************************
    // Event flags
    // ******************************************************
    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hour_flag_q   <= 1'b0;
            minute_flag_q <= 1'b0;
            second_flag_q <= 1'b0;
            comp_flag_q   <= 1'b0;
            tick_flag_q   <= 1'b0;
        end else begin
            // Hour and minute flags follow the carries
            hour_flag_q <= min_wrap ||
                (hour_flag_q && !(wr_stat && reg_wdata[STAT_HRF_BIT]));
            minute_flag_q <= sec_wrap ||
                (minute_flag_q && !(wr_stat && reg_wdata[STAT_MINF_BIT]));
            second_flag_q <= sec_tick ||
                (second_flag_q && !(wr_stat && reg_wdata[STAT_SECF_BIT]));
            // Last second starts when the previous second ends
            comp_flag_q <= comp_set ||
                (comp_flag_q && !(wr_stat && reg_wdata[STAT_COMPF_BIT]));
            tick_flag_q <= tb_event ||
                (tick_flag_q && !(wr_stat && reg_wdata[STAT_TBF_BIT]));
        end
    end

    // Requests follow flag and enable
    // Levels: they drop when the flag clears or its enable bit is cleared
    assign second_irq = second_flag_q && control_four_q[CTL4_SECOND_IRQ_ENABLE_BIT];
    assign minute_irq = minute_flag_q && control_four_q[CTL4_MINUTE_IRQ_ENABLE_BIT];
    assign hour_irq   = hour_flag_q && control_four_q[CTL4_HOUR_IRQ_ENABLE_BIT];
    assign comp_irq   = comp_flag_q && control_four_q[CTL4_COMP_CYCLE_IRQ_ENABLE_BIT];
    assign tick_irq   = tick_flag_q && control_four_q[CTL4_TBIE_BIT];

    // Calibration clock: toggles each second, giving 0.5 Hz square
    always_ff @(posedge core_clk) begin
        if (sys_rst) cal_clk_q <= 1'b0;
        else if (sec_tick) cal_clk_q <= !cal_clk_q;
    end
    assign calibration_clock   = cal_clk_q;
    assign low_freq_osc_enable = lfosc_sticky_q;

    // ******************************************************
    // Read path
    // ******************************************************
    // Reads have no side effects; unmapped addresses read zero
    logic [15:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ADDR_CONTROL_ONE:   rd_mux = {8'h00, control_one_q[7:6],
                                          lfosc_sticky_q,
                                          control_one_q[4:0]};
            ADDR_CONTROL_THREE: rd_mux = {14'h0000, protect_state};
            ADDR_CONTROL_FOUR:  rd_mux = {8'h00, control_four_q};
            ADDR_STATUS:        rd_mux = {8'h00, busy_q, 1'b0,
                                          hour_flag_q, minute_flag_q,
                                          second_flag_q, comp_flag_q,
                                          1'b0, tick_flag_q};
            ADDR_COMP_CONFIG:   rd_mux = {8'h00, compensation_config_q};
            ADDR_FREE_COUNT:    rd_mux = free_run_count_q;
            ADDR_MODULO:        rd_mux = modulo_value_q;
            ADDR_SECOND:        rd_mux = {10'h000, second_count_q};
            ADDR_MINUTE:        rd_mux = {10'h000, minute_count_q};
            ADDR_HOUR:          rd_mux = {11'h000, hour_count_q};
            ADDR_PRESCALE:      rd_mux = {8'h00, prescale_q};
            default:            rd_mux = 16'h0000;
        endcase
    end

    // Data stand one cycle after the read, else zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) rdata_q <= 16'h0000;
        else if (reg_read) rdata_q <= rd_mux;
        else rdata_q <= 16'h0000;
    end
    assign reg_rdata = rdata_q;
endmodule : rtc_calendar

// ===== rtc_calendar_asserts.sv
`timescale 1ns/100ps
module rtc_calendar_asserts
    import rtc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic        low_freq_osc_enable,
    input wire logic        second_irq,
    input wire logic        minute_irq,
    input wire logic        hour_irq
);
    // ******************************
    // Port-level properties
    // ******************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // Read data only in the cycle after a read
    property p_rdata_idle;
        !reg_read |=> reg_rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero after idle cycle");
    // Minute and hour reads never leave the legal range
    property p_min_range;
        reg_read && reg_addr == ADDR_MINUTE |=> reg_rdata <= 16'h003b;
    endproperty
    a_min_range: assert property (p_min_range)
        else $error("minute read above range");
    property p_hour_range;
        reg_read && reg_addr == ADDR_HOUR |=> reg_rdata <= 16'h0017;
    endproperty
    a_hour_range: assert property (p_hour_range)
        else $error("hour read above range");
    // Oscillator enable cannot drop without reset
    property p_lf_sticky;
        low_freq_osc_enable |=> low_freq_osc_enable;
    endproperty
    a_lf_sticky: assert property (p_lf_sticky)
        else $error("oscillator enable dropped");
    property p_irq_reset;
        $fell(sys_rst) |-> !second_irq && !minute_irq && !hour_irq;
    endproperty
    a_irq_reset: assert property (p_irq_reset)
        else $error("request active after reset");
    // Clearing the hour flag also drops its request
    property p_hour_clear;
        reg_write && reg_addr == ADDR_STATUS && reg_wdata[STAT_HRF_BIT]
            |=> !hour_irq;
    endproperty
    a_hour_clear: assert property (p_hour_clear)
        else $error("hour request not cleared");
    property p_wp_state;
        reg_read && reg_addr == ADDR_CONTROL_THREE
            |=> reg_rdata[15:2] == 14'h0 && reg_rdata[1:0] != 2'h3;
    endproperty
    a_wp_state: assert property (p_wp_state)
        else $error("protect state out of range");
    property p_wp_open;
        $fell(sys_rst) ##1 (reg_read && reg_addr == ADDR_CONTROL_THREE)
            |=> reg_rdata == 16'h0000;
    endproperty
    a_wp_open: assert property (p_wp_open)
        else $error("protection active after reset");
    c_hour: cover property (hour_irq);
    c_minute: cover property (minute_irq);
    c_clear: cover property (reg_write && reg_addr == ADDR_STATUS);
endmodule : rtc_calendar_asserts

bind rtc_calendar rtc_calendar_asserts rtc_calendar_asserts_inst (.*);

// ===== rtc_pkg.sv
package rtc_pkg;

    // ******************************************************
    // Register map (word index on the plain register port)
    // ******************************************************
    localparam logic [3:0] ADDR_CONTROL_ONE   = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_THREE = 4'h1;
    localparam logic [3:0] ADDR_CONTROL_FOUR  = 4'h2;
    localparam logic [3:0] ADDR_STATUS        = 4'h3;
    localparam logic [3:0] ADDR_COMP_CONFIG   = 4'h4;
    localparam logic [3:0] ADDR_FREE_COUNT    = 4'h5;
    localparam logic [3:0] ADDR_MODULO        = 4'h6;
    localparam logic [3:0] ADDR_SECOND        = 4'h7;
    localparam logic [3:0] ADDR_MINUTE        = 4'h8;
    localparam logic [3:0] ADDR_HOUR          = 4'h9;
    localparam logic [3:0] ADDR_PRESCALE      = 4'ha;

    // ******************************************************
    // Field positions
    // ******************************************************
    localparam int CTL1_ENABLE_BIT   = 7;
    localparam int CTL1_SOURCE_BIT   = 6;
    localparam int CTL1_LFOSC_BIT    = 5;
    localparam int CTL4_COMP_CYCLE_IRQ_ENABLE_BIT   = 4;
    localparam int CTL4_HOUR_IRQ_ENABLE_BIT     = 3;
    localparam int CTL4_MINUTE_IRQ_ENABLE_BIT    = 2;
    localparam int CTL4_SECOND_IRQ_ENABLE_BIT    = 1;
    localparam int CTL4_TBIE_BIT     = 0;
    localparam int STAT_BUSY_BIT     = 7;
    localparam int STAT_HRF_BIT      = 5;
    localparam int STAT_MINF_BIT     = 4;
    localparam int STAT_SECF_BIT     = 3;
    localparam int STAT_COMPF_BIT    = 2;
    localparam int STAT_TBF_BIT      = 0;
    localparam int CCR_CCS_MSB       = 7;
    localparam int CCR_CCS_LSB       = 6;
    localparam int CCR_Q_MSB         = 5;
    localparam int CCR_Q_LSB         = 0;
    localparam int HOUR_FIELD_MSB    = 4;

    // ******************************************************
    // Reset values and limits
    // ******************************************************
    localparam logic [7:0]  CTL_RESET      = 8'h00;
    localparam logic [15:0] MODULO_RESET   = 16'h0000;
    localparam logic [7:0]  CCR_RESET      = 8'h00;
    localparam logic [7:0]  PRESCALE_RESET = 8'h00;
    localparam logic [5:0]  MINUTE_MAX     = 6'h3b;
    localparam logic [5:0]  SECOND_MAX     = 6'h3b;
    localparam logic [4:0]  HOUR_MAX       = 5'h17;
    localparam logic [4:0]  MAIN_DIV       = 5'h1f;

    // Compensation period in seconds, by cycle selection
    localparam logic [5:0] PERIOD_SEL0 = 6'h05;
    localparam logic [5:0] PERIOD_SEL1 = 6'h0f;
    localparam logic [5:0] PERIOD_SEL2 = 6'h1e;
    localparam logic [5:0] PERIOD_SEL3 = 6'h3c;

    // Write-protect sequence codes
    localparam logic [1:0] WE_CODE_A = 2'h2;
    localparam logic [1:0] WE_CODE_B = 2'h1;
    localparam logic [1:0] WE_CODE_LOCK = 2'h3;

    typedef enum logic [1:0] {
        WP_OPEN   = 2'b00,
        WP_LOCKED = 2'b01,
        WP_STEP1  = 2'b10
    } wp_state_e;

endpackage : rtc_pkg

// ===== rtc_protect_fsm.sv
`timescale 1ns/100ps
// Write-protect sequence tracker on the two-bit write-enable field
module rtc_protect_fsm
    import rtc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       we_write,
    input  wire logic [1:0] we_data,
    output logic            protect_on,
    output logic [1:0]      protect_state
);
    wp_state_e state_q;
    wp_state_e state_d;

    // Two codes in order unlock, lock code relocks; slips restart
    always_comb begin
        state_d = state_q;
        if (we_write) begin
            case (state_q)
                WP_OPEN:   state_d = (we_data == WE_CODE_LOCK) ?
                                     WP_LOCKED : WP_OPEN;
                WP_LOCKED: state_d = (we_data == WE_CODE_A) ?
                                     WP_STEP1 : WP_LOCKED;
                WP_STEP1:  state_d = (we_data == WE_CODE_B) ?
                                     WP_OPEN : WP_LOCKED;
                default:   state_d = WP_LOCKED;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) state_q <= WP_OPEN;
        else state_q <= state_d;
    end

    assign protect_on    = state_q != WP_OPEN;
    assign protect_state = state_q;
endmodule : rtc_protect_fsm

// ===== rtc_tick_div.sv
`timescale 1ns/100ps
// Source selection and prescale: one-cycle count enable pulse
module rtc_tick_div
    import rtc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic       use_low_freq,
    input  wire logic [7:0] prescale_value,
    input  wire logic       main_osc_clock,
    input  wire logic       low_freq_osc_clock,
    output logic            count_en
);
    // Three-stage synchronisers, edge counted when stages 2 and 3 agree
    logic [2:0] main_sync_q;
    logic [2:0] low_sync_q;
    logic       main_lvl_q;
    logic       low_lvl_q;
    logic [7:0] pre_cnt_q;
    logic [4:0] div_cnt_q;
    wire        main_agree = main_sync_q[1] == main_sync_q[2];
    wire        low_agree  = low_sync_q[1] == low_sync_q[2];
    wire        main_rise  = main_agree && main_sync_q[2] && !main_lvl_q;
    wire        low_rise   = low_agree && low_sync_q[2] && !low_lvl_q;
    wire        pre_tick   = main_rise && (pre_cnt_q == prescale_value);
    wire        main_tick  = pre_tick && (div_cnt_q == MAIN_DIV);

    always_ff @(posedge core_clk) begin
        main_sync_q <= {main_sync_q[1:0], main_osc_clock};
        low_sync_q  <= {low_sync_q[1:0], low_freq_osc_clock};
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            main_lvl_q <= 1'b0;
            low_lvl_q  <= 1'b0;
        end else begin
            if (main_agree) main_lvl_q <= main_sync_q[2];
            if (low_agree) low_lvl_q <= low_sync_q[2];
        end
    end

    // Prescaler then divide by 32 on the main source
    always_ff @(posedge core_clk) begin
        if (sys_rst || !run) begin
            pre_cnt_q <= 8'h00;
            div_cnt_q <= 5'h00;
        end else if (main_rise) begin
            pre_cnt_q <= pre_tick ? 8'h00 : pre_cnt_q + 8'h01;
            if (pre_tick) div_cnt_q <= div_cnt_q + 5'h01;
        end
    end

    // Low-frequency source feeds the counter directly
    assign count_en = run && (use_low_freq ? low_rise : main_tick);
endmodule : rtc_tick_div

// ===== test_rtc_calendar.sv
`timescale 1ns/100ps
module test_rtc_calendar
    import rtc_pkg::*;
    ;
    logic        core_clk, sys_rst, reg_write, reg_read, lf_clk, lf_en;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [4:0]  irq;
    logic        main_clk, cal_clk;
    int          num_errors;
    int          n_checks;

    rtc_calendar rtc_calendar_inst (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .main_osc_clock(main_clk),
        .low_freq_osc_clock(lf_clk), .low_freq_osc_enable(lf_en),
        .calibration_clock(cal_clk), .second_irq(irq[4]),
        .minute_irq(irq[3]), .hour_irq(irq[2]), .comp_irq(irq[1]),
        .tick_irq(irq[0]));

    // ******************************
    // Clocks; crystal phase unrelated
    // ******************************
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        lf_clk = 1'b0;
        forever #15.3 lf_clk = ~lf_clk;
    end
    initial begin
        main_clk = 1'b0;
        forever #10 main_clk = ~main_clk;
    end

    // ******************************
    // Bus tasks
    // ******************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    // Masked read; data stand only in the following cycle
    task automatic rd(input logic [3:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        @(posedge core_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata & m, e);
    endtask : rd
    task automatic end_sim;
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim

    // ******************************
    // Main sequence
    // ******************************
    initial begin
        sys_rst = 1'b1;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        num_errors = 0;
        n_checks = 0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(ADDR_CONTROL_THREE, 16'hffff, 16'h0000);
        rd(ADDR_CONTROL_ONE, 16'hffff, 16'h0000);
        wr(ADDR_MINUTE, 16'h003b);
        wr(ADDR_MINUTE, 16'h003c);
        rd(ADDR_MINUTE, 16'hffff, 16'h003b);
        wr(ADDR_HOUR, 16'h0018);
        rd(ADDR_HOUR, 16'hffff, 16'h0000);
        // Lock, try a write, then walk the unlock codes
        wr(ADDR_CONTROL_THREE, {14'h0, WE_CODE_LOCK});
        rd(ADDR_CONTROL_THREE, 16'hffff, 16'h0001);
        wr(ADDR_MINUTE, 16'h0005);
        rd(ADDR_MINUTE, 16'hffff, 16'h003b);
        wr(ADDR_CONTROL_THREE, {14'h0, WE_CODE_A});
        wr(ADDR_CONTROL_THREE, {14'h0, WE_CODE_B});
        rd(ADDR_CONTROL_THREE, 16'hffff, 16'h0000);
        // 23:59:59 so one tick rolls every counter
        wr(ADDR_MODULO, 16'h0003);
        wr(ADDR_SECOND, 16'h003b);
        wr(ADDR_HOUR, 16'h0017);
        rd(ADDR_HOUR, 16'hffff, 16'h0017);
        wr(ADDR_CONTROL_FOUR, 16'h001f);
        wr(ADDR_CONTROL_ONE, 16'h00e0);
        for (int i = 0; i < 20000 && irq[2] !== 1'b1; i++) begin
            @(posedge core_clk);
        end
        if (irq[2] !== 1'b1) begin
            num_errors++;
            end_sim();
        end
        check({15'h0, cal_clk}, 16'h0001);
        rd(ADDR_HOUR, 16'hffff, 16'h0000);
        rd(ADDR_MINUTE, 16'hffff, 16'h0000);
        rd(ADDR_STATUS, 16'h0038, 16'h0038);
        rd(ADDR_STATUS, 16'h0001, 16'h0001);
        // Stop counting so no new event races the clears
        wr(ADDR_CONTROL_ONE, 16'h0000);
        rd(ADDR_CONTROL_ONE, 16'hffff, 16'h0020);
        check({15'h0, lf_en}, 16'h0001);
        wr(ADDR_STATUS, 16'h0000);
        rd(ADDR_STATUS, 16'h0038, 16'h0038);
        wr(ADDR_STATUS, 16'h003d);
        rd(ADDR_STATUS, 16'h003d, 16'h0000);
        check({11'h0, irq}, 16'h0000);
        // Main source, prescale zero: no second before 32 edges
        wr(ADDR_CONTROL_ONE, 16'h0080);
        repeat (100) @(posedge core_clk);
        rd(ADDR_STATUS, 16'h0008, 16'h0000);
        for (int i = 0; i < 2000 && irq[4] !== 1'b1; i++) begin
            @(posedge core_clk);
        end
        check({15'h0, irq[4]}, 16'h0001);
        end_sim();
    end
endmodule : test_rtc_calendar
